/* File: hw/scs_defs.svh */
// Register map, field positions, reset values and timing counts of the sample clock sequencer
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
`define SCS_CTRL_OFS 8'h00
`define SCS_LAST_OFS 8'h04
`define SCS_INTV_OFS 8'h08
`define SCS_COUNT_OFS 8'h0c
`define SCS_AMASK_OFS 8'h10
`define SCS_STAT_OFS 8'h14
`define SCS_DATA_OFS 8'h18
`define SCS_NREAD_OFS 8'h1c
`define SCS_ACYC_OFS 8'h20
`define SCS_CTRL_RUN 0
`define SCS_CTRL_EXT 1
`define SCS_CTRL_LIST 2
`define SCS_CTRL_TRIG 3
`define SCS_CTRL_OTRIG 5
`define SCS_CTRL_OEN 7
`define SCS_STAT_ST 8
`define SCS_STAT_DONE 10
`define SCS_STAT_VIOL 11
`define SCS_CTRL_RST 8'h04
`define SCS_INTV_RST 16'h0001
`define SCS_CLK_NS 8
`define SCS_MIN_TIME_NS 1300
`define SCS_MIN_CYC ((`SCS_MIN_TIME_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_SYNC_MARGIN_NS 100
`endif

/* File: hw/scs_pkg.sv */
// Types of the sample clock sequencer
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_IDLE = 2'b00,
        SCS_ARM = 2'b01,
        SCS_RUN = 2'b11,
        SCS_FLUSH = 2'b10
    } scs_state_t;
    typedef enum logic [1:0] {
        SCS_TRG_OFF = 2'b00,
        SCS_TRG_SINGLE = 2'b01,
        SCS_TRG_GATED = 2'b10
    } scs_trig_t;
endpackage : scs_pkg

/* File: hw/scs_sequencer.sv */
// Sample clock sequencer: channel list sequencing, conversion pipeline and hardware triggers
// Behaviour
// - Act only on rising edges of input and output clock lines.
// - Crystal timer paces sampling unless external clocking is selected.
// - Whole-list mode: each clock edge converts the whole list in order.
// - Whole-list: first channel at the edge, later ones one interval apart.
// - Single mode: one channel per edge, wrapping to the first after the last.
// - List clocking setting picks the mode; whole-list after reset.
// - No maximum external clock period and no timeout.
// - A value is read after the clock edge that follows its conversion.
// - Each sample goes setup, convert, read, one stage per edge.
// - Whole-list external: last value of a list read at next edge.
// - Analog entries wait extra edges for conversion; digital depth unchanged.
// - First read after start is discarded; burst tail read next burst.
// - Final values drained on the timer without another external edge.
// - Input and output triggers offer single shot and gated modes.
// - With hardware triggering nothing converts before the trigger.
// - Single shot waits for trigger high, runs until stop or count.
// - Gated runs while high, halts at list or channel boundaries.
//
// Added by the designer: the register offsets and register access over Wishbone.
`include "scs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer #(
    parameter int CH_W = 4,
    parameter int DW = 16,
    parameter int PIPE = 16,
    parameter int SYNC_MARGIN_NS = `SCS_SYNC_MARGIN_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic in_clk_i,
    input wire logic in_trig_i,
    input wire logic out_clk_i,
    input wire logic out_trig_i,
    input wire logic [DW-1:0] adc_data_i,
    output logic [CH_W-1:0] setup_chan_o,
    output logic conv_o,
    output logic [CH_W-1:0] conv_chan_o,
    output logic conv_analog_o,
    output logic rd_valid_o,
    output logic [CH_W-1:0] rd_chan_o,
    output logic out_upd_o
);
    localparam int PW = $clog2(PIPE);
    localparam int NCH = 1 << CH_W;
    localparam int SYNC_CYC = (SYNC_MARGIN_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS;

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [3:0] s1_r, s2_r, s3_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= {out_trig_i, out_clk_i, in_trig_i, in_clk_i};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    logic in_edge, out_edge, trig, otrig, in_fall;
    assign in_edge = s2_r[0] & ~s3_r[0];
    assign in_fall = ~s2_r[0] & s3_r[0];
    assign out_edge = s2_r[2] & ~s3_r[2];
    assign trig = s2_r[1];
    assign otrig = s2_r[3];

    // ----------------------------------------------------------------
    // Registers and bus slave
    // ----------------------------------------------------------------
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [CH_W-1:0] last_r, last_nxt;
    logic [15:0] intv_r, intv_nxt, intv_e;
    logic [31:0] cnt_r, cnt_nxt, nread_r, nread_nxt;
    logic [NCH-1:0] amask_r, amask_nxt;
    logic [7:0] rem_r, rem_nxt, acyc_r, acyc_nxt;
    logic [31:0] dat_nxt, wm, wv;
    logic ack_nxt, req, wr, viol_r, viol_nxt, done_r, done_nxt;
    logic [DW-1:0] data_r, data_nxt;
    logic [CH_W-1:0] dchan_r, dchan_nxt;
    logic fin;
    scs_pkg::scs_state_t st_r, st_nxt;
    logic [CH_W-1:0] ch_r, ch_nxt;
    logic [23:0] gap_r, gap_nxt, need;
    logic seen_r, seen_nxt, rd_v_nxt, viol_set;

    assign req = cyc_i & stb_i & ~ack_o;
    assign wr = req & we_i;
    assign wm = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign intv_e = (intv_r == 16'h0000) ? 16'h0001 : intv_r;
    assign need = ((ctrl_r[`SCS_CTRL_LIST]) ? 24'(intv_e) * (24'(last_r) + 24'h000001) : 24'(intv_e))
        + 24'(SYNC_CYC);
    assign viol_set = (st_r == scs_pkg::SCS_RUN) && ctrl_r[`SCS_CTRL_EXT] && in_edge && seen_r
        && (gap_r < need);

    always_comb begin
        ctrl_nxt = ctrl_r;
        last_nxt = last_r;
        intv_nxt = intv_r;
        cnt_nxt = cnt_r;
        amask_nxt = amask_r;
        viol_nxt = viol_r;
        ack_nxt = req;
        dat_nxt = '0;
        rem_nxt = rem_r;
        acyc_nxt = acyc_r;
        if (rem_r != 8'h00) begin
            rem_nxt = ({8'h00, rem_r} > intv_e) ? rem_r - intv_e[7:0] : 8'h00;
            acyc_nxt = acyc_r + 8'h01;
        end
        if (fin) begin
            ctrl_nxt[`SCS_CTRL_RUN] = 1'b0;
        end
        // External period shorter than the list needs: sticky violation flag
        if (viol_set) begin
            viol_nxt = 1'b1;
        end
        if (req) begin
            case (adr_i)
                `SCS_CTRL_OFS: dat_nxt = 32'(ctrl_r);
                `SCS_LAST_OFS: dat_nxt = 32'(last_r);
                `SCS_INTV_OFS: dat_nxt = 32'(intv_r);
                `SCS_COUNT_OFS: dat_nxt = cnt_r;
                `SCS_AMASK_OFS: dat_nxt = 32'(amask_r);
                `SCS_STAT_OFS: dat_nxt = 32'({viol_r, done_r, st_r, 8'(ch_r)});
                `SCS_DATA_OFS: dat_nxt = 32'({dchan_r, data_r});
                `SCS_NREAD_OFS: dat_nxt = nread_r;
                `SCS_ACYC_OFS: dat_nxt = 32'(acyc_r);
                default: dat_nxt = '0;
            endcase
        end
        wv = (dat_nxt & ~wm) | (dat_i & wm);
        if (wr) begin
            case (adr_i)
                `SCS_CTRL_OFS: ctrl_nxt = wv[7:0];
                `SCS_LAST_OFS: last_nxt = wv[CH_W-1:0];
                `SCS_INTV_OFS: begin
                    intv_nxt = wv[15:0];
                    rem_nxt = 8'(`SCS_MIN_CYC);
                    acyc_nxt = 8'h00;
                end
                `SCS_COUNT_OFS: cnt_nxt = wv;
                `SCS_AMASK_OFS: amask_nxt = wv[NCH-1:0];
                // Clear by writing one; a new violation in the same cycle wins
                `SCS_STAT_OFS: if (dat_i[`SCS_STAT_VIOL] && sel_i[1]) viol_nxt = viol_set;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `SCS_CTRL_RST;
            last_r <= '0;
            intv_r <= `SCS_INTV_RST;
            cnt_r <= '0;
            amask_r <= '0;
            viol_r <= 1'b0;
            ack_o <= 1'b0;
            dat_o <= '0;
            rem_r <= 8'(`SCS_MIN_CYC);
            acyc_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            last_r <= last_nxt;
            intv_r <= intv_nxt;
            cnt_r <= cnt_nxt;
            amask_r <= amask_nxt;
            viol_r <= viol_nxt;
            ack_o <= ack_nxt;
            dat_o <= dat_nxt;
            rem_r <= rem_nxt;
            acyc_r <= acyc_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer and conversion pipeline
    // ----------------------------------------------------------------
    logic [15:0] icnt_r, icnt_nxt;
    logic [31:0] nconv_r, nconv_nxt;
    logic [PIPE-1:0] pv_r, pv_nxt, sv;
    logic [CH_W-1:0] pc_r [PIPE];
    logic [CH_W-1:0] pc_nxt [PIPE];
    logic [CH_W-1:0] sc [PIPE];
    logic [PW-1:0] idx;
    logic tick, unit0, conv_nxt, ext, lst, run;
    logic [1:0] tmode;

    assign ext = ctrl_r[`SCS_CTRL_EXT];
    assign lst = ctrl_r[`SCS_CTRL_LIST];
    assign run = ctrl_r[`SCS_CTRL_RUN];
    assign tmode = ctrl_r[`SCS_CTRL_TRIG +: 2];
    assign unit0 = (ch_r == '0) | ~lst;
    // Timer paces internally, mid-list in whole-list mode and while draining; the pin paces list starts, and each channel in single mode
    assign tick = (st_r == scs_pkg::SCS_FLUSH) ? (icnt_r == 16'h0000) :
        (st_r != scs_pkg::SCS_RUN) ? 1'b0 :
        (ext && unit0) ? in_edge : (icnt_r == 16'h0000);
    assign idx = (acyc_r >= 8'(PIPE)) ? PW'(PIPE - 1) :
        (acyc_r == 8'h00) ? PW'(0) : PW'(acyc_r - 8'h01);

    genvar g;
    generate
        for (g = 0; g < PIPE; g++) begin : g_shift
            if (g < PIPE - 1) begin : g_mid
                assign sv[g] = pv_r[g+1];
                assign sc[g] = pc_r[g+1];
            end else begin : g_end
                assign sv[g] = 1'b0;
                assign sc[g] = '0;
            end
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        ch_nxt = ch_r;
        icnt_nxt = (icnt_r == 16'h0000) ? 16'h0000 : icnt_r - 16'h0001;
        nconv_nxt = nconv_r;
        pv_nxt = pv_r;
        pc_nxt = pc_r;
        conv_nxt = 1'b0;
        rd_v_nxt = 1'b0;
        fin = 1'b0;
        done_nxt = done_r;
        nread_nxt = nread_r;
        data_nxt = data_r;
        dchan_nxt = dchan_r;
        gap_nxt = (gap_r == 24'hffffff) ? gap_r : gap_r + 24'h000001;
        seen_nxt = seen_r;
        if (in_edge) begin
            gap_nxt = 24'h000001;
            seen_nxt = 1'b1;
        end
        if (tick) begin
            // Entry 0 empty on the first tick: that read is the discarded one
            rd_v_nxt = pv_r[0];
            if (pv_r[0]) begin
                nread_nxt = nread_r + 32'h00000001;
                data_nxt = adc_data_i;
                dchan_nxt = pc_r[0];
            end
            pv_nxt = sv;
            pc_nxt = sc;
            icnt_nxt = intv_e - 16'h0001;
        end
        case (st_r)
            scs_pkg::SCS_IDLE: begin
                seen_nxt = 1'b0;
                if (run) begin
                    done_nxt = 1'b0;
                    nconv_nxt = '0;
                    ch_nxt = '0;
                    pv_nxt = '0;
                    st_nxt = scs_pkg::SCS_ARM;
                end
            end
            scs_pkg::SCS_ARM: begin
                icnt_nxt = 16'h0000;
                if (!run) begin
                    st_nxt = scs_pkg::SCS_FLUSH;
                end else if (tmode == scs_pkg::SCS_TRG_OFF || trig) begin
                    st_nxt = scs_pkg::SCS_RUN;
                end
            end
            scs_pkg::SCS_RUN: begin
                if (!run && unit0) begin
                    st_nxt = scs_pkg::SCS_FLUSH;
                end else if (tick && tmode == scs_pkg::SCS_TRG_GATED && unit0 && !trig) begin
                    pv_nxt = pv_r;
                    pc_nxt = pc_r;
                    rd_v_nxt = 1'b0;
                    nread_nxt = nread_r;
                    data_nxt = data_r;
                    dchan_nxt = dchan_r;
                    st_nxt = scs_pkg::SCS_ARM;
                end else if (tick) begin
                    conv_nxt = 1'b1;
                    pv_nxt[amask_r[ch_r] ? idx : PW'(0)] = 1'b1;
                    pc_nxt[amask_r[ch_r] ? idx : PW'(0)] = ch_r;
                    ch_nxt = (ch_r == last_r) ? '0 : ch_r + 1'b1;
                    nconv_nxt = nconv_r + 32'h00000001;
                    if (cnt_r != 32'h00000000 && nconv_nxt == cnt_r) begin
                        st_nxt = scs_pkg::SCS_FLUSH;
                    end
                end
            end
            scs_pkg::SCS_FLUSH: begin
                if (pv_nxt == '0) begin
                    st_nxt = scs_pkg::SCS_IDLE;
                    fin = 1'b1;
                    done_nxt = 1'b1;
                end
            end
            default: st_nxt = scs_pkg::SCS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= scs_pkg::SCS_IDLE;
            ch_r <= '0;
            icnt_r <= '0;
            nconv_r <= '0;
            pv_r <= '0;
            for (int i = 0; i < PIPE; i++) pc_r[i] <= '0;
            done_r <= 1'b0;
            nread_r <= '0;
            data_r <= '0;
            dchan_r <= '0;
            gap_r <= '0;
            seen_r <= 1'b0;
            conv_o <= 1'b0;
            conv_chan_o <= '0;
            conv_analog_o <= 1'b0;
            setup_chan_o <= '0;
            rd_valid_o <= 1'b0;
            rd_chan_o <= '0;
        end else begin
            st_r <= st_nxt;
            ch_r <= ch_nxt;
            icnt_r <= icnt_nxt;
            nconv_r <= nconv_nxt;
            pv_r <= pv_nxt;
            pc_r <= pc_nxt;
            done_r <= done_nxt;
            nread_r <= nread_nxt;
            data_r <= data_nxt;
            dchan_r <= dchan_nxt;
            gap_r <= gap_nxt;
            seen_r <= seen_nxt;
            conv_o <= conv_nxt;
            conv_chan_o <= conv_nxt ? ch_r : conv_chan_o;
            conv_analog_o <= conv_nxt & amask_r[ch_r];
            setup_chan_o <= ch_nxt;
            rd_valid_o <= rd_v_nxt;
            rd_chan_o <= rd_v_nxt ? pc_r[0] : rd_chan_o;
        end
    end

    // ----------------------------------------------------------------
    // Output update clock and output trigger
    // ----------------------------------------------------------------
    logic oarm_r, oarm_nxt, upd_nxt;
    logic [1:0] omode;
    assign omode = ctrl_r[`SCS_CTRL_OTRIG +: 2];
    always_comb begin
        oarm_nxt = ctrl_r[`SCS_CTRL_OEN] & (oarm_r | (omode == scs_pkg::SCS_TRG_SINGLE && otrig));
        upd_nxt = ctrl_r[`SCS_CTRL_OEN] & out_edge & ((omode == scs_pkg::SCS_TRG_OFF) |
            ((omode == scs_pkg::SCS_TRG_SINGLE) & oarm_nxt) | ((omode == scs_pkg::SCS_TRG_GATED) & otrig));
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oarm_r <= 1'b0;
            out_upd_o <= 1'b0;
        end else begin
            oarm_r <= oarm_nxt;
            out_upd_o <= upd_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held two cycles");
    AST_ACK_REQ: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    AST_EDGE_CONV: assert property (st_r == scs_pkg::SCS_RUN && ext && !lst && in_edge && run &&
        tmode == scs_pkg::SCS_TRG_OFF |=> conv_o) else $error("rising edge did not convert");
    AST_FALL_IGNORED: assert property (st_r == scs_pkg::SCS_RUN && ext && !lst && in_fall
        |=> !conv_o) else $error("falling edge converted");
    AST_INT_SPACING: assert property (conv_o && !ext && intv_r == 16'h0008
        |=> !conv_o [*7]) else $error("internal timer spacing wrong");
    AST_LIST_ORDER: assert property (conv_o && conv_chan_o != last_r |-> ch_r == conv_chan_o + 1'b1)
        else $error("channel order broken");
    AST_WRAP: assert property (conv_o && conv_chan_o == last_r |-> ch_r == '0)
        else $error("no wrap after last channel");
    AST_NO_EARLY: assert property (st_r == scs_pkg::SCS_ARM |=> !conv_o)
        else $error("conversion before trigger");
    AST_GATE_HALT: assert property (tick && st_r == scs_pkg::SCS_RUN && run && tmode == scs_pkg::SCS_TRG_GATED
        && unit0 && !trig |=> !conv_o && st_r == scs_pkg::SCS_ARM) else $error("gate did not halt");
    AST_READ_TICK: assert property (rd_valid_o |-> $past(tick))
        else $error("read without clock tick");
    AST_DRAIN: assert property (st_r == scs_pkg::SCS_FLUSH && pv_r == '0 |=> st_r == scs_pkg::SCS_IDLE && done_r)
        else $error("drain did not finish");

    COV_WRAP: cover property (conv_o && conv_chan_o == last_r ##[1:200] conv_o);
    COV_GATE: cover property (st_r == scs_pkg::SCS_RUN ##1 st_r == scs_pkg::SCS_ARM);
    COV_DONE: cover property (st_r == scs_pkg::SCS_FLUSH ##1 st_r == scs_pkg::SCS_IDLE);
    COV_ANALOG_READ: cover property (conv_analog_o ##[1:300] rd_valid_o);
endmodule : scs_sequencer
`default_nettype wire

/* File: tb/scs_src_model.sv */
// External clock and trigger source that faces the sequencer's pins
`timescale 1ns/1ps
`default_nettype none
module scs_src_model #(
    parameter real HALF_NS = 62.5
) (
    output logic in_clk_o,
    output logic in_trig_o,
    output logic out_clk_o,
    output logic out_trig_o
);
    // Clock lines stand low outside frames
    initial begin
        in_clk_o = 1'b0;
        in_trig_o = 1'b0;
        out_clk_o = 1'b0;
        out_trig_o = 1'b0;
    end

    // Each rising edge at least a full 125 ns period after the last, above interval plus margin
    task automatic edges(input int n, input bit with_out, input int gap_ns);
        for (int i = 0; i < n; i++) begin
            #(HALF_NS);
            in_clk_o = 1'b1;
            out_clk_o = with_out;
            #(HALF_NS);
            in_clk_o = 1'b0;
            out_clk_o = 1'b0;
            #(gap_ns);
        end
    endtask : edges

    // Input and output trigger move together
    task automatic set_trig(input bit v);
        in_trig_o <= v;
        out_trig_o <= v;
    endtask : set_trig
endmodule : scs_src_model
`default_nettype wire

/* File: tb/scs_sequencer_tb.sv */
// Self-checking testbench of the sample clock sequencer
`include "scs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic we_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic [15:0] adc_data_i = 16'h5a3c;
    wire logic in_clk_i, in_trig_i, out_clk_i, out_trig_i;
    logic [31:0] dat_o;
    logic ack_o, conv_o, conv_analog_o, rd_valid_o, out_upd_o;
    logic [3:0] setup_chan_o, conv_chan_o, rd_chan_o;
    logic [3:0] chans[$], rdq[$], setq[$];
    int conv_t[$];
    int n_rd, n_ana, n_upd, cyc_cnt, failures, n_tests;

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    scs_sequencer u_scs_sequencer (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .in_clk_i(in_clk_i),
        .in_trig_i(in_trig_i), .out_clk_i(out_clk_i), .out_trig_i(out_trig_i), .adc_data_i(adc_data_i),
        .setup_chan_o(setup_chan_o), .conv_o(conv_o), .conv_chan_o(conv_chan_o), .conv_analog_o(conv_analog_o),
        .rd_valid_o(rd_valid_o), .rd_chan_o(rd_chan_o), .out_upd_o(out_upd_o));

    scs_src_model u_scs_src_model (.in_clk_o(in_clk_i), .in_trig_o(in_trig_i), .out_clk_o(out_clk_i),
        .out_trig_o(out_trig_i));

    // --------------------------------------------------------------
    // Monitor and tasks
    // --------------------------------------------------------------
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (conv_o === 1'b1) begin
            chans.push_back(conv_chan_o);
            conv_t.push_back(cyc_cnt);
            setq.push_back(setup_chan_o);
        end
        if (rd_valid_o === 1'b1) begin
            n_rd++;
            rdq.push_back(rd_chan_o);
        end
        if (conv_analog_o === 1'b1) n_ana++;
        if (out_upd_o === 1'b1) n_upd++;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        chans.delete();
        conv_t.delete();
        rdq.delete();
        setq.delete();
        n_rd = 0;
        n_ana = 0;
        n_upd = 0;
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= 4'hf;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 64);
        q = dat_o;
        check("wb_ack", {31'h0, ack_o}, 32'h1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        check(nm, q & m, exp);
    endtask : rd_chk

    task automatic wait_idle();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            wb(`SCS_STAT_OFS, 1'b0, 32'h0, q);
            n++;
        end while (q[9:8] !== 2'b00 && n < 3000);
        check("stat_idle", {30'h0, q[9:8]}, 32'h0);
    endtask : wait_idle

    task automatic check_seq(input logic [3:0] exp[$]);
        check("conv_count", chans.size(), exp.size());
        for (int i = 0; i < exp.size() && i < chans.size(); i++) begin
            check("conv_chan", {28'h0, chans[i]}, {28'h0, exp[i]});
        end
        check("rd_count", rdq.size(), exp.size());
        for (int i = 0; i < exp.size() && i < rdq.size(); i++) begin
            check("rd_chan", {28'h0, rdq[i]}, {28'h0, exp[i]});
        end
        for (int i = 0; i + 1 < exp.size() && i < setq.size(); i++) begin
            check("setup_chan", {28'h0, setq[i]}, {28'h0, exp[i+1]});
        end
    endtask : check_seq

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        do_reset();
        rd_chk("ctrl_rst", `SCS_CTRL_OFS, 32'hffffffff, 32'h04);
        rd_chk("intv_rst", `SCS_INTV_OFS, 32'hffffffff, 32'h01);
        rd_chk("stat_rst", `SCS_STAT_OFS, 32'hffffffff, 32'h00);
        wr(8'h40, 32'hffffffff);
        rd_chk("unmapped", 8'h40, 32'hffffffff, 32'h0);
        wr(`SCS_INTV_OFS, 32'h4);
        repeat (200) @(posedge clk_i);
        rd_chk("acyc_4", `SCS_ACYC_OFS, 32'hffffffff, (`SCS_MIN_CYC + 3) / 4);
        // Interval of a full analog time, so one cycle and no leading digital entries are needed
        wr(`SCS_INTV_OFS, 32'd163);
        repeat (200) @(posedge clk_i);
        rd_chk("acyc_163", `SCS_ACYC_OFS, 32'hffffffff, (`SCS_MIN_CYC + 162) / 163);
        // Internal timer, whole list, channel 2 analog
        wr(`SCS_LAST_OFS, 32'h2);
        wr(`SCS_AMASK_OFS, 32'h4);
        wr(`SCS_COUNT_OFS, 32'h6);
        wr(`SCS_CTRL_OFS, 32'h05);
        wait_idle();
        check_seq('{4'h0, 4'h1, 4'h2, 4'h0, 4'h1, 4'h2});
        for (int i = 1; i < conv_t.size(); i++) begin
            check("conv_gap", conv_t[i] - conv_t[i-1], 32'd163);
        end
        check("analog_cnt", n_ana, 32'h2);
        check("rd_cnt", n_rd, 32'h6);
        rd_chk("nread", `SCS_NREAD_OFS, 32'hffffffff, 32'h6);
        rd_chk("data", `SCS_DATA_OFS, 32'h000fffff, 32'h00025a3c);
        rd_chk("done", `SCS_STAT_OFS, 32'h00000c00, 32'h00000400);
        // External clock, whole list, output clock alongside, long quiet gaps
        do_reset();
        wr(`SCS_LAST_OFS, 32'h1);
        wr(`SCS_COUNT_OFS, 32'h4);
        wr(`SCS_CTRL_OFS, 32'h87);
        repeat (300) @(posedge clk_i);
        check("ext_no_timer", chans.size(), 32'h0);
        u_scs_src_model.edges(2, 1'b1, 20000);
        wait_idle();
        check_seq('{4'h0, 4'h1, 4'h0, 4'h1});
        check("list_gap", conv_t[1] - conv_t[0], 32'h1);
        check("out_upd", n_upd, 32'h2);
        rd_chk("nread_ext", `SCS_NREAD_OFS, 32'hffffffff, 32'h4);
        rd_chk("no_viol", `SCS_STAT_OFS, 32'h00000800, 32'h0);
        // External clock, one channel per edge, wrapping
        do_reset();
        wr(`SCS_LAST_OFS, 32'h2);
        wr(`SCS_COUNT_OFS, 32'h4);
        wr(`SCS_CTRL_OFS, 32'h03);
        u_scs_src_model.edges(4, 1'b0, 500);
        wait_idle();
        check_seq('{4'h0, 4'h1, 4'h2, 4'h0});
        check("rd_single", n_rd, 32'h4);
        // Single shot and gated triggers
        for (int m = 1; m <= 2; m++) begin
            do_reset();
            wr(`SCS_COUNT_OFS, 32'h3);
            wr(`SCS_INTV_OFS, 32'h8);
            wr(`SCS_CTRL_OFS, 32'h85 | 32'(m << 3) | 32'(m << 5));
            repeat (300) @(posedge clk_i);
            u_scs_src_model.edges(1, 1'b1, 200);
            check("pre_trigger", chans.size(), 32'h0);
            check("pre_otrig", n_upd, 32'h0);
            u_scs_src_model.set_trig(1'b1);
            if (m == 2) begin
                // Drop the gate after the second conversion, then reopen it
                repeat (12) @(posedge clk_i);
                u_scs_src_model.set_trig(1'b0);
                repeat (100) @(posedge clk_i);
                check("gate_halt", chans.size(), 32'h2);
                u_scs_src_model.set_trig(1'b1);
            end
            wait_idle();
            check("trig_conv", chans.size(), 32'h3);
            u_scs_src_model.edges(1, 1'b1, 200);
            check("post_otrig", n_upd, 32'h1);
            u_scs_src_model.set_trig(1'b0);
        end
        close_out();
    end

    initial begin
        #400000;
        failures++;
        close_out();
    end
endmodule : scs_sequencer_tb
`default_nettype wire
